// file: include/wwd_watchdog_map.vh
`ifndef WWD_WATCHDOG_MAP_VH
`define WWD_WATCHDOG_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define WWD_OFF_RESTART_COMMAND   4'h0
`define WWD_OFF_MODE_CONFIG       4'h4
`define WWD_OFF_FAULT_STATUS      4'h8

// ----------------------------------------------------------------
// Restart command fields
// ----------------------------------------------------------------
`define WWD_CR_KEY_MSB            31
`define WWD_CR_KEY_LSB            24
`define WWD_CR_KEY_VALUE          8'ha5
`define WWD_CR_RESTART_BIT        0

// ----------------------------------------------------------------
// Mode configuration fields
// ----------------------------------------------------------------
`define WWD_MR_LOAD_MSB           11
`define WWD_MR_LOAD_LSB           0
`define WWD_MR_IRQ_EN_BIT         12
`define WWD_MR_RST_EN_BIT         13
`define WWD_MR_PROC_ONLY_BIT      14
`define WWD_MR_DISABLE_BIT        15
`define WWD_MR_DELTA_MSB          27
`define WWD_MR_DELTA_LSB          16
`define WWD_MR_DBG_HALT_BIT       28
`define WWD_MR_IDLE_HALT_BIT      29
`define WWD_MR_USED_MASK          32'h3fffffff
`define WWD_MR_RESET_VALUE        32'h3fff2fff

// ----------------------------------------------------------------
// Fault status fields
// ----------------------------------------------------------------
`define WWD_SR_UNDERFLOW_BIT      0
`define WWD_SR_WINDOW_ERR_BIT     1
`define WWD_SR_RESET_VALUE        32'h00000000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WWD_HCLK_HZ               20000000
`define WWD_SLOW_CLK_HZ           32768
`define WWD_SLOW_DIV_CYCLES       (`WWD_HCLK_HZ / `WWD_SLOW_CLK_HZ)
`define WWD_PRESCALE_DIV          128

`endif

// file: design/wwd_watchdog.v
`timescale 1ns/1ps
`include "wwd_watchdog_map.vh"

module wwd_watchdog (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // System state, asynchronous to hclk
    input  wire        cpu_debug_state,
    input  wire        system_idle_state,
    input  wire        wdog_reset_done,
    // Fault signalling
    output reg         wdog_fault,
    output reg         fault_irq,
    output reg         all_reset_req,
    output reg         proc_reset_req
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function is_reg;
        input [31:0] addr;
        input [3:0]  off;
        begin
            is_reg = (addr[31:4] == 28'h0000000) && (addr[3:0] == off);
        end
    endfunction

    function [11:0] load_field;
        input [31:0] word;
        begin
            load_field = word[`WWD_MR_LOAD_MSB:`WWD_MR_LOAD_LSB];
        end
    endfunction

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    reg        dbg_meta_reg;
    reg        dbg_sync_reg;
    reg        idle_meta_reg;
    reg        idle_sync_reg;
    reg        rstd_meta_reg;
    reg        rstd_sync_reg;
    reg        rstd_prev_reg;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbg_meta_reg  <= 1'b0;
            dbg_sync_reg  <= 1'b0;
            idle_meta_reg <= 1'b0;
            idle_sync_reg <= 1'b0;
            rstd_meta_reg <= 1'b0;
            rstd_sync_reg <= 1'b0;
            rstd_prev_reg <= 1'b0;
        end else begin
            dbg_meta_reg  <= cpu_debug_state;
            dbg_sync_reg  <= dbg_meta_reg;
            idle_meta_reg <= system_idle_state;
            idle_sync_reg <= idle_meta_reg;
            rstd_meta_reg <= wdog_reset_done;
            rstd_sync_reg <= rstd_meta_reg;
            rstd_prev_reg <= rstd_sync_reg;
        end
    end

    // Rising edge of the generated-reset indication
    wire reset_gen_pulse = rstd_sync_reg & ~rstd_prev_reg;

    // ----------------------------------------------------------------
    // AHB-Lite address and data phase
    // ----------------------------------------------------------------
    // Zero wait states; every access answers OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    wire addr_phase = hsel & htrans[1] & hready;
    wire rd_take    = addr_phase & ~hwrite;
    wire wr_take    = addr_phase & hwrite;

    reg        wr_pend_reg;
    reg        wr_cr_reg;
    reg        wr_mr_reg;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_cr_reg   <= 1'b0;
            wr_mr_reg   <= 1'b0;
        end else begin
            wr_pend_reg <= wr_take;
            wr_cr_reg   <= wr_take & is_reg(haddr, `WWD_OFF_RESTART_COMMAND);
            wr_mr_reg   <= wr_take & is_reg(haddr, `WWD_OFF_MODE_CONFIG);
        end
    end

    // ----------------------------------------------------------------
    // Mode configuration
    // ----------------------------------------------------------------
    reg  [31:0] mode_reg;
    reg         mode_lock_reg;

    wire        mode_wr      = wr_pend_reg & wr_mr_reg & ~mode_lock_reg;
    wire [11:0] load_value   = load_field(mode_reg);
    wire [11:0] delta_value  = mode_reg[`WWD_MR_DELTA_MSB:`WWD_MR_DELTA_LSB];
    wire        irq_en       = mode_reg[`WWD_MR_IRQ_EN_BIT];
    wire        rst_en       = mode_reg[`WWD_MR_RST_EN_BIT];
    wire        proc_only    = mode_reg[`WWD_MR_PROC_ONLY_BIT];
    wire        cnt_disable  = mode_reg[`WWD_MR_DISABLE_BIT];
    wire        dbg_halt_en  = mode_reg[`WWD_MR_DBG_HALT_BIT];
    wire        idle_halt_en = mode_reg[`WWD_MR_IDLE_HALT_BIT];

    // Lock survives everything except hresetn, so a runaway program
    // cannot rewrite the mode after it was set once
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg      <= `WWD_MR_RESET_VALUE;
            mode_lock_reg <= 1'b0;
        end else if (mode_wr) begin
            mode_reg      <= hwdata & `WWD_MR_USED_MASK;
            mode_lock_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Restart command decode
    // ----------------------------------------------------------------
    reg  [11:0] count_reg;

    wire key_ok      = hwdata[`WWD_CR_KEY_MSB:`WWD_CR_KEY_LSB] == `WWD_CR_KEY_VALUE;
    // Wrong key or restart bit low: the write is dropped entirely
    wire restart_cmd = wr_pend_reg & wr_cr_reg & key_ok & hwdata[`WWD_CR_RESTART_BIT];
    // Window check is off when delta reaches the load value
    wire window_on   = delta_value < load_value;
    wire restart_err = restart_cmd & window_on & (count_reg > delta_value);
    wire restart_ok  = restart_cmd & ~restart_err;

    // ----------------------------------------------------------------
    // Slow clock and prescaler
    // ----------------------------------------------------------------
    // The slow clock stands for a free-running oscillator; restarts
    // only reset the 128 divider behind it
    reg  [15:0] slow_div_reg;
    reg  [6:0]  presc_reg;

    wire slow_tick  = slow_div_reg == (`WWD_SLOW_DIV_CYCLES - 1);
    wire halted     = (dbg_sync_reg & dbg_halt_en) | (idle_sync_reg & idle_halt_en);
    wire running    = ~cnt_disable & ~halted;
    wire presc_tick = running & slow_tick & (presc_reg == 7'h7f);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_div_reg <= 16'h0000;
        end else if (slow_tick) begin
            slow_div_reg <= 16'h0000;
        end else begin
            slow_div_reg <= slow_div_reg + 16'h0001;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_reg <= 7'h00;
        end else if (restart_ok | mode_wr) begin
            presc_reg <= 7'h00;
        end else if (running & slow_tick) begin
            presc_reg <= presc_reg + 7'h01;
        end
    end

    // ----------------------------------------------------------------
    // Down counter
    // ----------------------------------------------------------------
    wire underflow_evt = presc_tick & (count_reg == 12'h000);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= 12'hfff;
        end else if (mode_wr) begin
            count_reg <= load_field(hwdata);
        end else if (restart_ok) begin
            count_reg <= load_value;
        end else if (underflow_evt) begin
            // Reload so the period repeats while the fault is pending
            count_reg <= load_value;
        end else if (presc_tick) begin
            count_reg <= count_reg - 12'h001;
        end
    end

    // ----------------------------------------------------------------
    // Status flags and fault
    // ----------------------------------------------------------------
    reg  unf_flag_reg;
    reg  err_flag_reg;
    reg  fault_reg;

    wire status_rd   = rd_take & is_reg(haddr, `WWD_OFF_FAULT_STATUS);
    wire flag_clear  = status_rd | reset_gen_pulse;
    wire fault_event = (underflow_evt & rst_en) | restart_err;

    // New events win over a clear in the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unf_flag_reg <= 1'b0;
            err_flag_reg <= 1'b0;
            fault_reg    <= 1'b0;
        end else begin
            unf_flag_reg <= (unf_flag_reg & ~flag_clear) | underflow_evt;
            err_flag_reg <= (err_flag_reg & ~flag_clear) | restart_err;
            fault_reg    <= (fault_reg & ~flag_clear) | fault_event;
        end
    end

    // ----------------------------------------------------------------
    // Fault outputs
    // ----------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdog_fault     <= 1'b0;
            fault_irq      <= 1'b0;
            all_reset_req  <= 1'b0;
            proc_reset_req <= 1'b0;
        end else begin
            wdog_fault     <= fault_reg;
            fault_irq      <= irq_en & (unf_flag_reg | err_flag_reg);
            all_reset_req  <= fault_reg & rst_en & ~proc_only;
            proc_reset_req <= fault_reg & rst_en & proc_only;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Sampled in the address phase so the status value returned is the
    // one that the read clears
    reg  [31:0] rd_next;

    always @* begin
        rd_next = 32'h00000000;
        if (is_reg(haddr, `WWD_OFF_MODE_CONFIG)) begin
            rd_next = mode_reg;
        end else if (is_reg(haddr, `WWD_OFF_FAULT_STATUS)) begin
            rd_next[`WWD_SR_UNDERFLOW_BIT]  = unf_flag_reg;
            rd_next[`WWD_SR_WINDOW_ERR_BIT] = err_flag_reg;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `WWD_SR_RESET_VALUE;
        end else if (rd_take) begin
            hrdata <= rd_next;
        end
    end

endmodule

// file: verif/wwd_watchdog_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checks of the windowed watchdog
// ----------------------------------------
module wwd_watchdog_checker (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Fault side
    input wire logic        wdog_reset_done,
    input wire logic        wdog_fault,
    input wire logic        fault_irq,
    input wire logic        all_reset_req,
    input wire logic        proc_reset_req
);
    wire  take = hsel && htrans[1] && hready;
    logic rd_q;
    logic cr_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            cr_q <= 1'b0;
        end else begin
            rd_q <= take && !hwrite;
            cr_q <= take && hwrite && haddr == 32'h0;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ready_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    req_exclusive_a: assert property (!(all_reset_req && proc_reset_req))
        else $error("both reset requests high");
    req_needs_fault_a: assert property ((all_reset_req || proc_reset_req) |-> wdog_fault)
        else $error("reset request without fault");
    status_read_clear_a: assert property ((take && !hwrite && haddr == 32'h8) |->
        ##2 !(wdog_fault || fault_irq || all_reset_req || proc_reset_req))
        else $error("fault outputs not cleared by status read");
    bad_key_quiet_a: assert property ((cr_q && (hwdata[31:24] != 8'ha5 || !hwdata[0]) && !wdog_fault)
        |-> ##2 !wdog_fault)
        else $error("ignored restart write raised fault");
    done_clears_a: assert property ($rose(wdog_reset_done) |-> ##[1:6] !wdog_fault)
        else $error("fault not cleared after generated reset");
    rdata_hold_a: assert property (!rd_q |-> $stable(hrdata))
        else $error("read data changed without a read");
    rdata_upper_a: assert property (rd_q |-> hrdata[31:30] == 2'b00)
        else $error("read data upper bits not zero");
endmodule

bind wwd_watchdog wwd_watchdog_checker chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .wdog_reset_done(wdog_reset_done), .wdog_fault(wdog_fault), .fault_irq(fault_irq),
    .all_reset_req(all_reset_req), .proc_reset_req(proc_reset_req)
);

// file: verif/wwd_reset_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Reset controller seen by the watchdog
// ----------------------------------------
module wwd_reset_ctrl_model #(
    parameter int DELAY = 20
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Requests in, completion out
    input  wire logic all_reset_req,
    input  wire logic proc_reset_req,
    output logic      wdog_reset_done
);
    int cnt;

    // Short requests are ignored so a quick status read wins the race
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt             <= 0;
            wdog_reset_done <= 1'b0;
        end else if (all_reset_req || proc_reset_req) begin
            cnt             <= cnt + 1;
            wdog_reset_done <= cnt >= DELAY;
        end else begin
            cnt             <= 0;
            wdog_reset_done <= 1'b0;
        end
    end
endmodule

// file: verif/windowed_watchdog_timer_tb.sv
`timescale 1ns/1ps
`include "wwd_watchdog_map.vh"
module windowed_watchdog_timer_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        dbg = 1'b0;
    logic        idle = 1'b0;
    wire         hready;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire         done;
    wire         wdog_fault;
    wire         fault_irq;
    wire         all_reset_req;
    wire         proc_reset_req;
    logic [31:0] q;
    int          miscompares = 0;
    int          check_count = 0;

    assign hready = hreadyout;

    wwd_watchdog dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cpu_debug_state(dbg), .system_idle_state(idle), .wdog_reset_done(done),
        .wdog_fault(wdog_fault), .fault_irq(fault_irq), .all_reset_req(all_reset_req),
        .proc_reset_req(proc_reset_req)
    );

    wwd_reset_ctrl_model #(.DELAY(20)) rc_u (
        .hclk(hclk), .hresetn(hresetn), .all_reset_req(all_reset_req), .proc_reset_req(proc_reset_req),
        .wdog_reset_done(done)
    );

    initial begin
        forever #25 hclk = ~hclk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Outputs packed as fault, irq, all-reset, processor-reset
    task automatic check_outs(input logic [3:0] exp);
        check("fault outputs", {28'h0, exp}, {28'h0, wdog_fault, fault_irq, all_reset_req, proc_reset_req});
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        q = hrdata;
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    task automatic t_defaults();
        do_reset();
        bus(0, 32'h4, 0); check("mode after reset", 32'h3fff2fff, q);
        bus(0, 32'h8, 0); check("status after reset", 32'h0, q);
        bus(0, 32'h0, 0); check("command read", 32'h0, q);
        bus(0, 32'h10, 0); check("unmapped read", 32'h0, q);
        bus(1, 32'h0, 32'ha5000001);
        repeat (3) @(posedge hclk);
        check_outs(4'h0);
    endtask

    task automatic t_window();
        do_reset();
        bus(1, 32'h4, 32'h00017fff);
        bus(1, 32'h4, 32'h3fff2fff);
        bus(0, 32'h4, 0); check("mode locked", 32'h00017fff, q);
        bus(1, 32'h0, 32'h5a000001);
        bus(1, 32'h0, 32'ha5000000);
        repeat (3) @(posedge hclk);
        check_outs(4'h0);
        bus(1, 32'h0, 32'ha5000001);
        repeat (2) @(posedge hclk);
        check_outs(4'hd);
        bus(0, 32'h8, 0); check("status error", 32'h2, q);
        repeat (3) @(posedge hclk);
        check_outs(4'h0);
        bus(0, 32'h8, 0); check("status cleared", 32'h0, q);
    endtask

    task automatic t_disabled();
        do_reset();
        bus(1, 32'h4, 32'h00008fff);
        bus(1, 32'h0, 32'ha5000001);
        repeat (2) @(posedge hclk);
        check_outs(4'h8);
        bus(0, 32'h8, 0); check("status error disabled", 32'h2, q);
    endtask

    task automatic t_underflow();
        int n;
        n = 0;
        do_reset();
        bus(1, 32'h4, 32'h00003000);
        while (!wdog_fault && n < 140 * `WWD_SLOW_DIV_CYCLES) begin
            @(posedge hclk);
            n++;
        end
        check("underflow not early", 32'h1, {31'h0, n >= 127 * `WWD_SLOW_DIV_CYCLES});
        @(posedge hclk);
        check_outs(4'he);
        n = 0;
        while (wdog_fault && n < 60) begin
            @(posedge hclk);
            n++;
        end
        check_outs(4'h0);
        bus(0, 32'h8, 0); check("status after watchdog reset", 32'h0, q);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge hclk);
        miscompares++;
        final_report();
    end

    initial begin
        t_defaults();
        t_window();
        t_disabled();
        t_underflow();
        final_report();
    end
endmodule
